// ===== design/btde_engine.sv
`timescale 1ns/1ns
// How it works
// - 8-bit strongest hysteresis, reset 0x80, used only in strongest mode.
// - challenger replaces strongest only when ahead by the strongest hysteresis.
// - 8-bit long-press timer, zero disables, one second per count.
// - three reporting methods: all, first, strongest.
// - report-all shows every touched button at once.
// - report-first holds earliest touch until it is released.
// - report-strongest shows the sensor with the largest signal.
// - interrupt on touch, release or both, selectable.
// - debounce counts qualifying consecutive samples before committing.
// - one debounce sample per scan period.
// - touch when ticks exceed threshold plus threshold times percentage.
// - release when ticks fall below threshold minus threshold times percentage.
// - one hysteresis percentage shared by all buttons.
// - averaging suspended for a sensor at the positive averaging threshold.
// - three or more sensors at that threshold start compensation.
// - large negative ticks trigger compensation for fresh baseline values.
// - negative counter starts when ticks drop below negative threshold.
// - compensation when negative counter reaches the configured maximum.
// - nonzero stuck-at timeout forces release after that many seconds.
// - after forced release, a real lift allows a normal new touch.
// - stuck-at timeout zero disables the stuck-at timer.
// - method code 00 all, 01 first (reset), 10 strongest, 11 reserved.
// - interrupt code 00 masked, 01 touch, 10 release, 11 both (reset).
// - debounce code 00 none, 01 two, 10 three, 11 four samples.
// - first mode: long-press expiry idles analog output, status waits.
module btde_engine
	import btde_pkg::*;
#(
	parameter int unsigned NB      = 8,
	parameter int unsigned TW      = 16,
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   sys_rst,
	// register port
	input  wire logic [7:0]             reg_addr,
	input  wire logic                   reg_wr,
	input  wire logic [7:0]             reg_wdata,
	output logic      [7:0]             reg_rdata,
	// sensor samples
	input  wire logic                   scan_strobe,
	input  wire logic [NB-1:0][TW-1:0]  sensor_ticks,
	input  wire logic [NB-1:0][TW-1:0]  button_threshold,
	// results
	output logic      [NB-1:0]          button_status,
	output logic                        analog_active,
	output logic                        button_irq,
	output logic      [NB-1:0]          averaging_suspend,
	output logic                        compensation_request
);
	localparam int unsigned IW = $clog2(NB);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic signed [TW+1:0] widen(input logic [TW-1:0] thr, input logic [7:0] pct);
		logic [TW+7:0] prod;
		prod  = thr * pct;
		widen = $signed({2'h0, TW'(prod / PERCENT_FULL)});
	endfunction
	function automatic logic signed [TW+1:0] sx(input logic [TW-1:0] v);
		sx = $signed({{2{v[TW-1]}}, v});
	endfunction
	function automatic logic signed [TW+1:0] scaled(input logic [7:0] v);
		scaled = $signed((TW+2)'({v, 2'h0}));
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	btde_cfg_s  cfg_q;
	logic [7:0] avgth_q, negth_q, negmax_q, hyst_q, stuck_q, shyst_q, lpress_q;
	logic [7:0] rdata_d;
	always_comb begin
		unique case (reg_addr)
			OFS_CFG:    rdata_d = cfg_q;
			OFS_AVGTH:  rdata_d = avgth_q;
			OFS_NEGTH:  rdata_d = negth_q;
			OFS_NEGMAX: rdata_d = negmax_q;
			OFS_HYST:   rdata_d = hyst_q;
			OFS_STUCK:  rdata_d = stuck_q;
			OFS_SHYST:  rdata_d = shyst_q;
			OFS_LPRESS: rdata_d = lpress_q;
			default:    rdata_d = 8'h00;
		endcase
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q     <= RST_CFG;
			avgth_q   <= RST_AVGTH;
			negth_q   <= RST_NEGTH;
			negmax_q  <= RST_NEGMAX;
			hyst_q    <= RST_HYST;
			stuck_q   <= RST_STUCK;
			shyst_q   <= RST_SHYST;
			lpress_q  <= RST_LPRESS;
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_d;
			if (reg_wr) begin
				unique case (reg_addr)
					OFS_CFG:    cfg_q    <= reg_wdata;
					OFS_AVGTH:  avgth_q  <= reg_wdata;
					OFS_NEGTH:  negth_q  <= reg_wdata;
					OFS_NEGMAX: negmax_q <= reg_wdata;
					OFS_HYST:   hyst_q   <= reg_wdata;
					OFS_STUCK:  stuck_q  <= reg_wdata;
					OFS_SHYST:  shyst_q  <= reg_wdata;
					OFS_LPRESS: lpress_q <= reg_wdata;
					default:    ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// decision engine
	// ----------------------------------------
	logic [31:0]         div_q, div_d;
	logic                sec_tick;
	logic [NB-1:0]       tch_q, tch_d, blk_q, blk_d, rep_q, rep_d, susp_q, susp_d;
	logic [NB-1:0]       above, below;
	logic [NB-1:0][1:0]  db_q, db_d;
	logic [NB-1:0][7:0]  stk_q, stk_d, neg_q, neg_d;
	logic [IW-1:0]       sel_q, sel_d;
	logic                selv_q, selv_d, lpdone_q, lpdone_d, irq_d, comp_d;
	logic [7:0]          lp_q, lp_d;
	assign sec_tick = (div_q == SEC_CYC - 1);
	always_comb begin
		int unsigned     hot;
		logic            negtrig;
		logic [7:0]      negmax;
		logic [IW-1:0]   best;
		logic            bestv;
		hot     = 0;
		negtrig = 1'b0;
		best    = sel_q;
		bestv   = 1'b0;
		// a reserved zero maximum behaves as one so the counter cannot stall
		negmax  = (negmax_q == 8'h00) ? 8'h01 : negmax_q;
		div_d   = sec_tick ? 32'h0 : div_q + 32'h1;
		tch_d   = tch_q;
		blk_d   = blk_q;
		db_d    = db_q;
		stk_d   = stk_q;
		neg_d   = neg_q;
		susp_d  = susp_q;
		for (int i = 0; i < NB; i++) begin
			// one shared percentage widens every threshold
			above[i] = sx(sensor_ticks[i]) > sx(button_threshold[i]) + widen(button_threshold[i], hyst_q);
			below[i] = sx(sensor_ticks[i]) < sx(button_threshold[i]) - widen(button_threshold[i], hyst_q);
			if (scan_strobe) begin
				if (!tch_q[i]) begin
					if (above[i] && !blk_q[i]) begin
						if (db_q[i] >= cfg_q.tch_db) begin
							tch_d[i] = 1'b1;
							db_d[i]  = 2'h0;
							stk_d[i] = 8'h00;
						end else begin
							db_d[i] = db_q[i] + 2'h1;
						end
					end else begin
						db_d[i] = 2'h0;
					end
					if (below[i]) begin
						blk_d[i] = 1'b0;
					end
				end else if (below[i]) begin
					if (db_q[i] >= cfg_q.rel_db) begin
						tch_d[i] = 1'b0;
						db_d[i]  = 2'h0;
						stk_d[i] = 8'h00;
					end else begin
						db_d[i] = db_q[i] + 2'h1;
					end
				end else begin
					db_d[i] = 2'h0;
				end
				susp_d[i] = sx(sensor_ticks[i]) >= scaled(avgth_q);
				if (susp_d[i]) begin
					hot = hot + 1;
				end
				if (sx(sensor_ticks[i]) < -scaled(negth_q)) begin
					neg_d[i] = (neg_q[i] == 8'hFF) ? neg_q[i] : neg_q[i] + 8'h1;
					if (neg_q[i] + 8'h1 >= negmax) begin
						negtrig = 1'b1;
					end
				end else begin
					neg_d[i] = 8'h00;
				end
			end
			// stuck-at timer in whole seconds, off when zero
			if (tch_q[i] && tch_d[i] && stuck_q != 8'h00 && sec_tick) begin
				if (stk_q[i] + 8'h1 >= stuck_q) begin
					tch_d[i] = 1'b0;
					blk_d[i] = 1'b1;
					stk_d[i] = 8'h00;
				end else begin
					stk_d[i] = stk_q[i] + 8'h1;
				end
			end
		end
		comp_d = scan_strobe && (negtrig || hot >= MIN_HOT_SENSORS);
		// reporting method selection
		sel_d  = sel_q;
		selv_d = selv_q && tch_d[sel_q];
		rep_d  = '0;
		unique case (cfg_q.method)
			MODE_ALL: begin
				rep_d = tch_d;
			end
			MODE_FIRST: begin
				if (!selv_d) begin
					for (int i = NB - 1; i >= 0; i--) begin
						if (tch_d[i]) begin
							sel_d  = IW'(i);
							selv_d = 1'b1;
						end
					end
				end
				rep_d[sel_d] = selv_d;
			end
			MODE_STRONG: begin
				for (int i = 0; i < NB; i++) begin
					if (tch_d[i]) begin
						if (selv_d) begin
							// challenger must lead by the hysteresis
							if (sx(sensor_ticks[i]) >= sx(sensor_ticks[best]) + $signed({2'h0, TW'(shyst_q)})) begin
								best = IW'(i);
							end
						end else if (!bestv || sx(sensor_ticks[i]) > sx(sensor_ticks[best])) begin
							best  = IW'(i);
							bestv = 1'b1;
						end
					end
				end
				if (selv_d || bestv) begin
					sel_d  = best;
					selv_d = 1'b1;
				end
				rep_d[sel_d] = selv_d;
			end
			default: begin
				selv_d = 1'b0;
			end
		endcase
		// analog output idles when long press expires; status holds
		lp_d     = 8'h00;
		lpdone_d = 1'b0;
		if (cfg_q.method == MODE_FIRST && selv_d && selv_q && sel_d == sel_q) begin
			lp_d     = lp_q;
			lpdone_d = lpdone_q && lpress_q != 8'h00;
			if (sec_tick && lpress_q != 8'h00 && !lpdone_q) begin
				lp_d     = lp_q + 8'h1;
				lpdone_d = (lp_q + 8'h1 >= lpress_q);
			end
		end
		irq_d = (cfg_q.irq_sel[0] && |(rep_d & ~rep_q)) || (cfg_q.irq_sel[1] && |(rep_q & ~rep_d));
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 32'h0;
			tch_q <= '0;
			blk_q <= '0;
			rep_q <= '0;
			susp_q <= '0;
			db_q <= '0;
			stk_q <= '0;
			neg_q <= '0;
			sel_q <= '0;
			selv_q <= 1'b0;
			lp_q <= 8'h00;
			lpdone_q <= 1'b0;
			button_irq <= 1'b0;
			compensation_request <= 1'b0;
		end else begin
			div_q <= div_d;
			tch_q <= tch_d;
			blk_q <= blk_d;
			rep_q <= rep_d;
			susp_q <= susp_d;
			db_q <= db_d;
			stk_q <= stk_d;
			neg_q <= neg_d;
			sel_q <= sel_d;
			selv_q <= selv_d;
			lp_q <= lp_d;
			lpdone_q <= lpdone_d;
			button_irq <= irq_d;
			compensation_request <= comp_d;
		end
	end

	assign button_status     = rep_q;
	assign averaging_suspend = susp_q;
	assign analog_active     = |rep_q && !(cfg_q.method == MODE_FIRST && lpdone_q);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	strong_onehot_a: assert property (cfg_q.method == MODE_STRONG |-> $onehot0(rep_q))
		else $error("strongest mode reports several buttons");
	first_hold_a: assert property ($past(cfg_q.method) == MODE_FIRST && cfg_q.method == MODE_FIRST
		&& $past(rep_q) != 0 && $past(tch_q & rep_q) == $past(rep_q) && (tch_q & $past(rep_q)) != 0
		|-> rep_q == $past(rep_q))
		else $error("first touch replaced before release");
	all_mode_a: assert property ($past(cfg_q.method) == MODE_ALL && cfg_q.method == MODE_ALL |-> rep_q == tch_q)
		else $error("report all differs from touch state");
	irq_mask_a: assert property (button_irq |-> $past(cfg_q.irq_sel) != 2'h0 && $past(rep_q) != rep_q)
		else $error("interrupt without enabled event");
	touch_fast_a: assert property (scan_strobe && cfg_q.tch_db == 2'h0 && !tch_q[0] && above[0] && !blk_q[0]
		|=> tch_q[0])
		else $error("undebounced touch not taken");
	release_fast_a: assert property (scan_strobe && cfg_q.rel_db == 2'h0 && tch_q[0] && below[0] |=> !tch_q[0])
		else $error("undebounced release not taken");
	touch_db_a: assert property (scan_strobe && !tch_q[0] && db_q[0] < cfg_q.tch_db |=> !tch_q[0])
		else $error("touch committed before debounce count");
	comp_scan_a: assert property (compensation_request |-> $past(scan_strobe))
		else $error("compensation outside a scan");
	stuck_off_a: assert property (!blk_q[0] ##1 blk_q[0] |-> $past(stuck_q) != 8'h00 && $past(sec_tick))
		else $error("forced release with timer off");
	lp_off_a: assert property (lpress_q == 8'h00 && $past(lpress_q) == 8'h00 |-> !lpdone_q)
		else $error("long press expired while disabled");
	irq_seen_c: cover property (button_irq);
	comp_seen_c: cover property (compensation_request);
	strong_swap_c: cover property (cfg_q.method == MODE_STRONG && rep_q != 0 ##1 rep_q != 0 && $changed(rep_q));
	stuck_seen_c: cover property (|blk_q ##[1:20] ~|blk_q);
endmodule

// ===== design/btde_pkg.sv
package btde_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CFG    = 8'h20;
	localparam logic [7:0] OFS_AVGTH  = 8'h21;
	localparam logic [7:0] OFS_NEGTH  = 8'h22;
	localparam logic [7:0] OFS_NEGMAX = 8'h23;
	localparam logic [7:0] OFS_HYST   = 8'h24;
	localparam logic [7:0] OFS_STUCK  = 8'h25;
	localparam logic [7:0] OFS_SHYST  = 8'h26;
	localparam logic [7:0] OFS_LPRESS = 8'h27;
	localparam logic [7:0] OFS_RSVA   = 8'h28;
	localparam logic [7:0] OFS_RSVB   = 8'h29;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_CFG    = 8'h70;
	localparam logic [7:0] RST_AVGTH  = 8'h50;
	localparam logic [7:0] RST_NEGTH  = 8'h50;
	localparam logic [7:0] RST_NEGMAX = 8'h01;
	localparam logic [7:0] RST_HYST   = 8'h0A;
	localparam logic [7:0] RST_STUCK  = 8'h00;
	localparam logic [7:0] RST_SHYST  = 8'h80;
	localparam logic [7:0] RST_LPRESS = 8'h00;
	// ----------------------------------------
	// field encodings and scaling
	// ----------------------------------------
	localparam logic [1:0] MODE_ALL    = 2'h0;
	localparam logic [1:0] MODE_FIRST  = 2'h1;
	localparam logic [1:0] MODE_STRONG = 2'h2;
	localparam int unsigned TICK_SCALE_SHIFT = 2;
	localparam int unsigned PERCENT_FULL     = 100;
	localparam int unsigned MIN_HOT_SENSORS  = 3;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned SECOND_NS     = 1000000000;
	localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [1:0] method;
		logic [1:0] irq_sel;
		logic [1:0] rel_db;
		logic [1:0] tch_db;
	} btde_cfg_s;
endpackage

// ===== testbench/button_touch_decision_engine_test.sv
`timescale 1ns/1ns
module button_touch_decision_engine_test;
	import btde_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	localparam int unsigned NBT = 4;
	localparam logic [15:0] T_0   = 16'h0000;
	localparam logic [15:0] T_ON  = 16'h0096;
	localparam logic [15:0] T_AVG = 16'h0140;
	logic                  clock                = 1'b0;
	logic                  sys_rst              = 1'b1;
	logic [7:0]            reg_addr             = 8'h00;
	logic                  reg_wr               = 1'b0;
	logic [7:0]            reg_wdata            = 8'h00;
	logic [7:0]            reg_rdata;
	logic                  scan_strobe          = 1'b0;
	logic [NBT-1:0][15:0]  sensor_ticks         = '0;
	logic [NBT-1:0][15:0]  button_threshold     = '0;
	logic [NBT-1:0]        button_status;
	logic                  analog_active;
	logic                  button_irq;
	logic [NBT-1:0]        averaging_suspend;
	logic                  compensation_request;
	int                    err_total            = 0;
	int                    checks               = 0;
	int                    irq_n                = 0;
	int                    comp_n               = 0;
	int                    n0;
	// reset values and the reserved/unmapped places read as zero
	logic [15:0]           rows [11] = '{16'h2070, 16'h2150, 16'h2250, 16'h2301, 16'h240A, 16'h2500,
		16'h2680, 16'h2700, 16'h2800, 16'h2900, 16'h2A00};

	btde_engine #(.NB(NBT), .TW(16), .SEC_CYC(50)) btde_engine_inst (
		.clock                (clock),
		.sys_rst              (sys_rst),
		.reg_addr             (reg_addr),
		.reg_wr               (reg_wr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.scan_strobe          (scan_strobe),
		.sensor_ticks         (sensor_ticks),
		.button_threshold     (button_threshold),
		.button_status        (button_status),
		.analog_active        (analog_active),
		.button_irq           (button_irq),
		.averaging_suspend    (averaging_suspend),
		.compensation_request (compensation_request)
	);

	initial begin
		forever #5 clock = ~clock;
	end

	// pulses are counted rather than sampled, so the exact answer cycle does not matter
	always @(posedge clock) begin
		if (button_irq === 1'b1) irq_n <= irq_n + 1;
		if (compensation_request === 1'b1) comp_n <= comp_n + 1;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		repeat (2) @(posedge clock);
		#1;
		chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	// one scan period: ticks presented with the strobe, outputs settled afterwards
	task automatic scan(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		@(posedge clock);
		sensor_ticks <= {T_0, c, b, a};
		scan_strobe  <= 1'b1;
		@(posedge clock);
		scan_strobe  <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic st(input string nm, input logic [3:0] exp);
		chk(nm, {12'h000, exp}, {12'h000, button_status});
	endtask

	task automatic summarize;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		sys_rst          <= 1'b0;
		button_threshold <= {4{16'h0064}};
		foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
		wr(OFS_SHYST, 8'h10);
		rd(OFS_SHYST, 8'h10);
		wr(OFS_RSVA, 8'h5A);
		rd(OFS_RSVA, 8'h00);
		// hysteresis edges: touch above 110, release below 90, first mode
		n0 = irq_n;
		scan(16'h006E, T_0, T_0);
		st("touch_edge", 4'h0);
		scan(16'h006F, T_ON, T_0);
		st("touch_first", 4'h1);
		chk("analog_on", 16'h0001, {15'h0000, analog_active});
		scan(16'h005A, T_ON, T_0);
		st("release_edge", 4'h1);
		scan(16'h0059, T_0, T_0);
		st("release", 4'h0);
		chk("irq_both", 16'h0002, 16'(irq_n - n0));
		// report all
		wr(OFS_CFG, 8'h30);
		scan(T_ON, T_ON, T_0);
		st("all", 4'h3);
		scan(T_0, T_0, T_0);
		// debounce: touch two samples, release three samples
		wr(OFS_CFG, 8'h39);
		scan(T_ON, T_0, T_0);
		st("db_touch1", 4'h0);
		scan(T_ON, T_0, T_0);
		st("db_touch2", 4'h1);
		repeat (2) scan(T_0, T_0, T_0);
		st("db_rel2", 4'h1);
		scan(T_0, T_0, T_0);
		st("db_rel3", 4'h0);
		// every interrupt selection code
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CFG, {2'h0, c[1:0], 4'h0});
			n0 = irq_n;
			scan(T_ON, T_0, T_0);
			chk("irq_on_touch", {15'h0000, c[0]}, 16'(irq_n - n0));
			n0 = irq_n;
			scan(T_0, T_0, T_0);
			chk("irq_on_release", {15'h0000, c[1]}, 16'(irq_n - n0));
		end
		// strongest with a hysteresis of 16 ticks
		wr(OFS_CFG, 8'hB0);
		scan(16'h00C8, T_0, T_0);
		st("strong0", 4'h1);
		scan(16'h00C8, 16'h00D7, T_0);
		st("strong_hold", 4'h1);
		scan(16'h00C8, 16'h00D8, T_0);
		st("strong_swap", 4'h2);
		scan(T_0, T_0, T_0);
		// averaging suspend and common-mode compensation at 320 ticks
		n0 = comp_n;
		scan(T_AVG, T_AVG, 16'h013F);
		chk("avg_suspend", 16'h0003, {12'h000, averaging_suspend});
		chk("comp_two", 16'h0000, 16'(comp_n - n0));
		scan(T_AVG, T_AVG, T_AVG);
		chk("comp_three", 16'h0001, 16'(comp_n - n0));
		scan(T_0, T_0, T_0);
		// negative ticks: -320 does not count, -321 does
		wr(OFS_NEGMAX, 8'h02);
		n0 = comp_n;
		scan(16'hFEBF, T_0, T_0);
		chk("neg_first", 16'h0000, 16'(comp_n - n0));
		scan(16'hFEBF, T_0, T_0);
		chk("neg_second", 16'h0001, 16'(comp_n - n0));
		scan(T_0, T_0, T_0);
		wr(OFS_NEGMAX, 8'h01);
		n0 = comp_n;
		scan(16'hFEC0, T_0, T_0);
		scan(16'hFEBF, T_0, T_0);
		chk("neg_max_one", 16'h0001, 16'(comp_n - n0));
		scan(T_0, T_0, T_0);
		// stuck-at of one second; a short second still needs up to one second of hold
		wr(OFS_CFG, 8'h70);
		wr(OFS_STUCK, 8'h01);
		repeat (30) scan(T_ON, T_0, T_0);
		st("stuck_release", 4'h0);
		scan(T_0, T_0, T_0);
		// two seconds, so the free-running second cannot cut the new touch before it is seen
		wr(OFS_STUCK, 8'h02);
		scan(T_ON, T_0, T_0);
		st("stuck_retouch", 4'h1);
		// timer off: touch stays, long press idles only the analog output
		wr(OFS_STUCK, 8'h00);
		wr(OFS_LPRESS, 8'h01);
		repeat (30) scan(T_ON, T_0, T_0);
		st("stuck_off", 4'h1);
		chk("long_press", 16'h0000, {15'h0000, analog_active});
		// a second reset restores the register defaults
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		st("reset_status", 4'h0);
		@(posedge clock);
		sys_rst <= 1'b0;
		rd(OFS_SHYST, 8'h80);
		summarize();
	end
endmodule
